//--- dv/cifb_checker.sv
// assertions on the cpu interrupt flag bank top ports
// assumes one clock domain with synchronous active low reset
`timescale 1ns/1ps

module cifb_checker
  import cifb_pkg::*;
(
  input wire logic            clk,
  input wire logic            reset_n,
  input wire logic [7:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  input wire cifb_src_type    src_event,
  input wire cifb_src_type    module_clear,
  input wire cifb_src_type    module_left,
  input wire logic            vec_taken,
  input wire logic            vec_req,
  input wire logic [IDXW-1:0] vec_num,
  input wire logic [NSRC-1:0] flags_pending,
  input wire logic            irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_take;
    vec_req && vec_taken;
  endsequence
  // a same-cycle software write or event wins over the vector clear
  sequence s_tmr_take;
    s_take ##0 (vec_num inside {[3:6]} && !reg_wr && src_event == '0);
  endsequence

  AST_RADIO_PAIR: assert property (src_event.radio |=>
    flags_pending[SRC_RADIO]) else $error("radio event lost");
  AST_EVENT_SETS: assert property (|src_event |=>
    (flags_pending & $past(src_event)) == $past(src_event))
    else $error("event did not set flag");
  AST_SW_RADIO: assert property (
    reg_wr && reg_addr == ADDR_RADIO && reg_wdata[1:0] != 2'h0 |=>
    flags_pending[SRC_RADIO]) else $error("radio write gave no request");
  AST_RDATA_IDLE: assert property (!reg_rd |=>
    reg_rdata == 8'h00) else $error("read data outside read");
  AST_TMR_CLR: assert property (s_tmr_take |=>
    !flags_pending[$past(vec_num)]) else $error("timer flag kept");
  AST_VEC_DROP: assert property (s_take |=> !vec_req)
    else $error("request stayed after take");
  AST_VEC_START: assert property ($rose(vec_req) |->
    flags_pending[vec_num]) else $error("vector without flag");
  AST_HOLD: assert property (!reg_wr && !vec_req |=>
    (flags_pending & $past(flags_pending)) == $past(flags_pending))
    else $error("flag dropped by itself");
  AST_REASSERT: assert property (|(module_clear & module_left) |=>
    (flags_pending & $past(module_clear & module_left)) ==
    $past(module_clear & module_left)) else $error("no re-assert");
endmodule

bind cifb_top cifb_checker cifb_checker_inst (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .src_event(src_event),
  .module_clear(module_clear), .module_left(module_left),
  .vec_taken(vec_taken), .vec_req(vec_req), .vec_num(vec_num),
  .flags_pending(flags_pending), .irq(irq));

//--- dv/cifb_cpu_model.sv
// cpu core model: takes a requested vector after a fixed delay
// assumes vec_req stays up until taken; dly 0 answers promptly
`timescale 1ns/1ps

module cifb_cpu_model #(
  parameter int DLY = 2
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic vec_req,
  output logic      vec_taken
);
  int cnt_q;

  // one take per request, a repeated take would re-enter the routine
  always_ff @(posedge clk) begin
    if (!reset_n || !vec_req || vec_taken) begin
      cnt_q     <= 0;
      vec_taken <= 1'b0;
    end else if (cnt_q == DLY) begin
      vec_taken <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

//--- dv/cifb_top_tb.sv
// bench for the cpu interrupt flag bank: registers, flags, irq, vectors
// assumes the cpu model on the vector port and a 25 MHz clock
`timescale 1ns/1ps

module cifb_top_tb
  import cifb_pkg::*;
;
  logic            clk = 0;
  logic            reset_n = 0;
  logic            reg_wr = 0;
  logic            reg_rd = 0;
  logic [7:0]      reg_addr = 0;
  logic [7:0]      reg_wdata = 0;
  logic [7:0]      reg_rdata;
  logic [7:0]      a;
  cifb_src_type    src_event = '0;
  cifb_src_type    module_clear = '0;
  cifb_src_type    module_left = '0;
  logic            vec_taken;
  logic            vec_req;
  logic            irq;
  logic [IDXW-1:0] vec_num;
  logic [NSRC-1:0] flags_pending;
  int              fail_count = 0;
  int              checks_done = 0;
  logic [7:0]      em [2:13] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
    8'h20, 8'h80, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};

  cifb_top cifb_top_inst (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .module_clear(module_clear), .module_left(module_left),
    .vec_taken(vec_taken), .vec_req(vec_req), .vec_num(vec_num),
    .flags_pending(flags_pending), .irq(irq));
  cifb_cpu_model #(.DLY(3)) cifb_cpu_model_inst (.clk(clk),
    .reset_n(reset_n), .vec_req(vec_req), .vec_taken(vec_taken));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic ev(input logic [NSRC-1:0] e, c, l);
    @(posedge clk);
    src_event <= e;
    module_clear <= c;
    module_left <= l;
    @(posedge clk);
    src_event <= '0;
    module_clear <= '0;
    module_left <= '0;
    #1;
  endtask

  task automatic wtv(input logic v);
    for (int n = 0; n < 40 && vec_req !== v; n++) begin
      @(posedge clk);
      #1;
    end
    if (vec_req !== v) begin
      fail_count++;
      end_sim;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_RADIO, 8'h00);
    rd(ADDR_TMR, 8'h00);
    rd(ADDR_PORTS, 8'h00);
    rd(8'h00, 8'h00);
    ev(14'h0001, '0, '0);
    rd(ADDR_RADIO, 8'h03);
    wr(ADDR_RADIO, 8'h00);
    wr(ADDR_RADIO, 8'h02);
    rd(ADDR_RADIO, 8'h02);
    chk(flags_pending[SRC_RADIO], 1'b1);
    wr(ADDR_RADIO, 8'h00);
    ev(14'h0002, '0, '0);
    rd(ADDR_AES, 8'h03);
    wr(ADDR_AES, 8'h01);
    rd(ADDR_AES, 8'h01);
    chk(flags_pending[SRC_AES], 1'b1);
    wr(ADDR_AES, 8'h00);
    for (int i = 2; i < NSRC; i++) begin
      a = i < 9 ? ADDR_TMR : ADDR_PORTS;
      ev(NSRC'(1) << i, '0, '0);
      rd(a, em[i]);
      rd(a, em[i]);
      wr(a, 8'h00);
      rd(a, 8'h00);
    end
    wr(ADDR_ENA_HI, 8'hff);
    rd(ADDR_ENA_HI, 8'h3f);
    wr(ADDR_ENA_HI, 8'h00);
    rd(ADDR_STS_LO, 8'hff);
    rd(ADDR_STS_HI, 8'h3f);
    wr(ADDR_MSK_LO, 8'h08);
    ev(14'h0008, '0, '0);
    chk(irq, 1'b1);
    rd(ADDR_STS_LO, 8'h08);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(ADDR_MSK_LO, 8'h00);
    ev(14'h0010, '0, '0);
    chk(irq, 1'b0);
    rd(ADDR_STS_LO, 8'h10);
    wr(ADDR_TMR, 8'h00);
    ev('0, 14'h0004, 14'h0004);
    rd(ADDR_TMR, 8'h01);
    wr(ADDR_TMR, 8'h00);
    ev('0, 14'h0004, '0);
    rd(ADDR_TMR, 8'h00);
    wr(ADDR_ENA_LO, 8'h18);
    ev(14'h0018, '0, '0);
    for (int k = 0; k < 2; k++) begin
      wtv(1'b1);
      chk(vec_num, 4'(SRC_T1 + k));
      wtv(1'b0);
    end
    rd(ADDR_TMR, 8'h00);
    wr(ADDR_ENA_LO, 8'h00);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule

//--- hdl/cifb_flag_cell.sv
// one cpu interrupt flag bit
// assumes hardware set, hardware clear and software write are clk-synchronous
`timescale 1ns/1ps

module cifb_flag_cell
  import cifb_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic hw_set,
  input  wire logic hw_clr,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output logic      flag_q
);

  // a new event beats both a software clear and the vector clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag_q <= FLAG_RST;
    end else if (hw_set) begin
      flag_q <= 1'b1;
    end else if (sw_wr) begin
      flag_q <= sw_val;
    end else if (hw_clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule

//--- hdl/cifb_pkg.sv
// cpu interrupt flag bank: register map, flag layout, source indices, types
// assumes an 8-bit register port and one 25 MHz clock with synchronous reset

package cifb_pkg;

  localparam int unsigned NSRC = 14;
  localparam int unsigned IDXW = 4;

  // register offsets
  localparam logic [7:0] ADDR_AES    = 8'h98;
  localparam logic [7:0] ADDR_RADIO  = 8'h9b;
  localparam logic [7:0] ADDR_TMR    = 8'hc0;
  localparam logic [7:0] ADDR_PORTS  = 8'he8;
  localparam logic [7:0] ADDR_STS_LO = 8'hf0;
  localparam logic [7:0] ADDR_STS_HI = 8'hf1;
  localparam logic [7:0] ADDR_MSK_LO = 8'hf2;
  localparam logic [7:0] ADDR_MSK_HI = 8'hf3;
  localparam logic [7:0] ADDR_ENA_LO = 8'hf4;
  localparam logic [7:0] ADDR_ENA_HI = 8'hf5;

  // field positions
  localparam int unsigned PAIR_HI_BIT = 1;
  localparam int unsigned PAIR_LO_BIT = 0;
  localparam int unsigned TMR_RSV_BIT = 6;

  // source indices, lowest index wins the vector
  localparam int unsigned SRC_RADIO  = 0;
  localparam int unsigned SRC_AES    = 1;
  localparam int unsigned SRC_DMA    = 2;
  localparam int unsigned SRC_T1     = 3;
  localparam int unsigned SRC_T2     = 4;
  localparam int unsigned SRC_T3     = 5;
  localparam int unsigned SRC_T4     = 6;
  localparam int unsigned SRC_PORT0  = 7;
  localparam int unsigned SRC_SLEEP  = 8;
  localparam int unsigned SRC_P2USB  = 9;
  localparam int unsigned SRC_SER0TX = 10;
  localparam int unsigned SRC_SER1TX = 11;
  localparam int unsigned SRC_PORT1  = 12;
  localparam int unsigned SRC_WDT    = 13;

  // register and bit of each source's (low) flag, index 13 first
  localparam logic [NSRC-1:0][7:0] SRC_ADDR = {
    ADDR_PORTS, ADDR_PORTS, ADDR_PORTS, ADDR_PORTS, ADDR_PORTS,
    ADDR_TMR, ADDR_TMR, ADDR_TMR, ADDR_TMR, ADDR_TMR, ADDR_TMR, ADDR_TMR,
    ADDR_AES, ADDR_RADIO};
  localparam logic [NSRC-1:0][2:0] SRC_BIT = {
    3'h4, 3'h3, 3'h2, 3'h1, 3'h0,
    3'h7, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0,
    3'h0, 3'h0};

  // timer 1..4 flags clear when the cpu vectors to them
  localparam logic [NSRC-1:0] HW_CLR_MASK = 14'h0078;
  // radio and aes carry a paired flag
  localparam logic [NSRC-1:0] PAIR_MASK   = 14'h0003;

  // reset values
  localparam logic       FLAG_RST = 1'b0;
  localparam logic [7:0] REG_RST  = 8'h00;

  typedef struct packed {
    logic wdt;
    logic port1;
    logic ser1tx_audio;
    logic ser0tx;
    logic port2_usb;
    logic sleep;
    logic port0;
    logic t4;
    logic t3;
    logic t2;
    logic t1;
    logic dma;
    logic aes;
    logic radio;
  } cifb_src_type;

  typedef enum logic [1:0] {
    VEC_IDLE = 2'b01,
    VEC_WAIT = 2'b10
  } cifb_vec_state_type;

endpackage

//--- hdl/cifb_prio_pick.sv
// fixed-priority pick: lowest set index of a request vector
// assumes the request vector is already gated by the enables
`timescale 1ns/1ps

module cifb_prio_pick
  import cifb_pkg::*;
(
  input  wire logic [NSRC-1:0] req,
  output logic                 pick_valid,
  output logic [IDXW-1:0]      pick_idx
);

  always_comb begin
    pick_valid = 1'b0;
    pick_idx   = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick_valid = 1'b1;
        pick_idx   = IDXW'(i);
      end
    end
  end

endmodule

//--- hdl/cifb_top.sv
// cpu interrupt flag bank: flag registers, event status, vector request
// assumes register port strobes are one-cycle pulses, never both at once,
// and that sources present one-cycle event pulses synchronous to clk
`timescale 1ns/1ps

module cifb_top
  import cifb_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  input  cifb_src_type      src_event,
  input  cifb_src_type      module_clear,
  input  cifb_src_type      module_left,
  input  wire logic         vec_taken,
  output logic              vec_req,
  output logic [IDXW-1:0]   vec_num,
  output logic [NSRC-1:0]   flags_pending,
  output logic              irq
);

  logic [NSRC-1:0] ev_vec;
  logic [NSRC-1:0] mclr_vec;
  logic [NSRC-1:0] mleft_vec;
  logic [NSRC-1:0] set_vec;
  logic [NSRC-1:0] flag_lo;
  logic [NSRC-1:0] flag_hi;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] hw_clr_vec;
  logic [NSRC-1:0] status_q;
  logic [NSRC-1:0] status_d;
  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] enable_q;
  logic            rsv_q;
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic            pick_valid;
  logic [IDXW-1:0] pick_idx;
  logic [IDXW-1:0] vec_num_q;
  logic [NSRC-1:0] sw_wr_vec;
  logic [NSRC-1:0] sw_val_vec;
  logic            vec_take;
  logic            wr_tmr;
  logic            wr_msk_lo;
  logic            wr_msk_hi;
  logic            wr_ena_lo;
  logic            wr_ena_hi;
  logic            rd_sts_lo;
  logic            rd_sts_hi;
  logic            aes_flag_high;
  logic            aes_flag_low;
  logic            radio_flag_high;
  logic            radio_flag_low;
  logic            sleep_timer_flag;
  logic            port0_pin_flag;
  logic            timer4_flag;
  logic            timer3_flag;
  logic            timer2_flag;
  logic            timer1_flag;
  logic            dma_done_flag;
  logic            watchdog_flag;
  logic            port1_pin_flag;
  logic            serial1_tx_flag;
  logic            serial0_tx_flag;
  logic            port2_pin_flag;
  logic [7:0]      img_aes;
  logic [7:0]      img_radio;
  logic [7:0]      img_tmr;
  logic [7:0]      img_ports;
  cifb_vec_state_type vec_state_q;
  cifb_vec_state_type vec_state_d;

  assign ev_vec    = src_event;
  assign mclr_vec  = module_clear;
  assign mleft_vec = module_left;

  // register decode for the control side; the strobes never overlap
  assign wr_tmr    = reg_wr && (reg_addr == ADDR_TMR);
  assign wr_msk_lo = reg_wr && (reg_addr == ADDR_MSK_LO);
  assign wr_msk_hi = reg_wr && (reg_addr == ADDR_MSK_HI);
  assign wr_ena_lo = reg_wr && (reg_addr == ADDR_ENA_LO);
  assign wr_ena_hi = reg_wr && (reg_addr == ADDR_ENA_HI);
  assign rd_sts_lo = reg_rd && (reg_addr == ADDR_STS_LO);
  assign rd_sts_hi = reg_rd && (reg_addr == ADDR_STS_HI);

  // write hit of each source's flag register
  always_comb begin
    sw_wr_vec = '0;
    for (int i = 0; i < NSRC; i++) begin
      sw_wr_vec[i] = reg_wr && (reg_addr == SRC_ADDR[i]);
    end
  end

  // written value of each source's low flag bit
  always_comb begin
    sw_val_vec = '0;
    for (int i = 0; i < NSRC; i++) begin
      sw_val_vec[i] = reg_wdata[SRC_BIT[i]];
    end
  end

  // a module flag cleared while others of that source are still pending
  // raises the cpu flag again so no request is lost
  assign set_vec = ev_vec | (mclr_vec & mleft_vec);

  // a take outside a request is ignored, so it can never clear a flag
  assign vec_take = (vec_state_q == VEC_WAIT) && vec_taken;

  // hardware clear only reaches the flag the cpu has just vectored to
  always_comb begin
    hw_clr_vec = '0;
    if (vec_take) begin
      hw_clr_vec[vec_num_q] = 1'b1;
    end
    hw_clr_vec = hw_clr_vec & HW_CLR_MASK;
  end

  // flag cells: a low cell per source at its documented register and bit, plus a high cell for each paired source
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_flag
      cifb_flag_cell u_lo (
        .clk     (clk),
        .reset_n (reset_n),
        .hw_set  (set_vec[g]),
        .hw_clr  (hw_clr_vec[g]),
        .sw_wr   (sw_wr_vec[g]),
        .sw_val  (sw_val_vec[g]),
        .flag_q  (flag_lo[g])
      );
      if (PAIR_MASK[g]) begin : g_pair
        // the source sets both halves; one register write loads both halves, each from its own bit
        cifb_flag_cell u_hi (
          .clk     (clk),
          .reset_n (reset_n),
          .hw_set  (set_vec[g]),
          .hw_clr  (1'b0),
          .sw_wr   (sw_wr_vec[g]),
          .sw_val  (reg_wdata[PAIR_HI_BIT]),
          .flag_q  (flag_hi[g])
        );
      end else begin : g_single
        assign flag_hi[g] = 1'b0;
      end
    end
  endgenerate

  // either half of a paired flag is enough to request the cpu
  assign pend = flag_lo | flag_hi;
  assign flags_pending = pend;

  // named fields of the four flag registers
  assign aes_flag_high    = flag_hi[SRC_AES];
  assign aes_flag_low     = flag_lo[SRC_AES];
  assign radio_flag_high  = flag_hi[SRC_RADIO];
  assign radio_flag_low   = flag_lo[SRC_RADIO];
  assign sleep_timer_flag = flag_lo[SRC_SLEEP];
  assign port0_pin_flag   = flag_lo[SRC_PORT0];
  assign timer4_flag      = flag_lo[SRC_T4];
  assign timer3_flag      = flag_lo[SRC_T3];
  assign timer2_flag      = flag_lo[SRC_T2];
  assign timer1_flag      = flag_lo[SRC_T1];
  assign dma_done_flag    = flag_lo[SRC_DMA];
  assign watchdog_flag    = flag_lo[SRC_WDT];
  assign port1_pin_flag   = flag_lo[SRC_PORT1];
  // the second serial transmitter and audio transmit share this bit
  assign serial1_tx_flag  = flag_lo[SRC_SER1TX];
  assign serial0_tx_flag  = flag_lo[SRC_SER0TX];
  // the port 2 pins and the usb controller share this bit
  assign port2_pin_flag   = flag_lo[SRC_P2USB];

  // register images; bits 7..5 of the ports register are unused
  assign img_aes   = {6'h00, aes_flag_high, aes_flag_low};
  assign img_radio = {6'h00, radio_flag_high, radio_flag_low};
  assign img_tmr   = {sleep_timer_flag, rsv_q, port0_pin_flag, timer4_flag,
                      timer3_flag, timer2_flag, timer1_flag, dma_done_flag};
  assign img_ports = {3'h0, watchdog_flag, port1_pin_flag, serial1_tx_flag,
                      serial0_tx_flag, port2_pin_flag};

  // reserved timer/dma bit: stored and read back only; a one written here
  // makes software re-enter its service routine, so keep it zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rsv_q <= FLAG_RST;
    end else if (wr_tmr) begin
      rsv_q <= reg_wdata[TMR_RSV_BIT];
    end
  end

  // event status: sticky, cleared by reading its half; set wins
  always_comb begin
    status_d = status_q;
    if (rd_sts_lo) begin
      status_d[7:0] = '0;
    end
    if (rd_sts_hi) begin
      status_d[NSRC-1:8] = '0;
    end
    status_d = status_d | ev_vec;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt mask, same layout as the status pair
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_q <= '0;
    end else if (wr_msk_lo) begin
      mask_q[7:0] <= reg_wdata;
    end else if (wr_msk_hi) begin
      mask_q[NSRC-1:8] <= reg_wdata[NSRC-9:0];
    end
  end

  // level output: stays high until a read clears the status half
  assign irq = |(status_q & mask_q);

  // vector enables: a flag still sets while disabled, it just never vectors
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enable_q <= '0;
    end else if (wr_ena_lo) begin
      enable_q[7:0] <= reg_wdata;
    end else if (wr_ena_hi) begin
      enable_q[NSRC-1:8] <= reg_wdata[NSRC-9:0];
    end
  end

  cifb_prio_pick u_pick (
    .req        (pend & enable_q),
    .pick_valid (pick_valid),
    .pick_idx   (pick_idx)
  );

  // vector request: raised the cycle after an enabled flag is seen set
  always_comb begin
    vec_state_d = vec_state_q;
    case (vec_state_q)
      VEC_IDLE: begin
        if (pick_valid) begin
          vec_state_d = VEC_WAIT;
        end
      end
      VEC_WAIT: begin
        // withdraw if software cleared or disabled the flag meanwhile
        if (vec_taken || !(pend[vec_num_q] && enable_q[vec_num_q])) begin
          vec_state_d = VEC_IDLE;
        end
      end
      default: begin
        vec_state_d = VEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vec_state_q <= VEC_IDLE;
    end else begin
      vec_state_q <= vec_state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vec_num_q <= '0;
    end else if (vec_state_q == VEC_IDLE && pick_valid) begin
      vec_num_q <= pick_idx;
    end
  end

  assign vec_req = (vec_state_q == VEC_WAIT);
  assign vec_num = vec_num_q;

  // read image; unmapped addresses read zero
  always_comb begin
    rdata_d = REG_RST;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_AES: begin
          rdata_d = img_aes;
        end
        ADDR_RADIO: begin
          rdata_d = img_radio;
        end
        ADDR_TMR: begin
          rdata_d = img_tmr;
        end
        ADDR_PORTS: begin
          rdata_d = img_ports;
        end
        ADDR_STS_LO: begin
          rdata_d = status_q[7:0];
        end
        ADDR_STS_HI: begin
          rdata_d = {2'h0, status_q[NSRC-1:8]};
        end
        ADDR_MSK_LO: begin
          rdata_d = mask_q[7:0];
        end
        ADDR_MSK_HI: begin
          rdata_d = {2'h0, mask_q[NSRC-1:8]};
        end
        ADDR_ENA_LO: begin
          rdata_d = enable_q[7:0];
        end
        ADDR_ENA_HI: begin
          rdata_d = {2'h0, enable_q[NSRC-1:8]};
        end
        default: begin
          rdata_d = REG_RST;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= REG_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // source-to-field map, for reference:
  // timer/dma register: sleep 7 port0 5
  // t4..t1 4..1, dma 0
  // ports register: wdt 4 port1 3
  // serial1/audio tx 2 serial0 tx 1
  // port2/usb 0

endmodule
